//--- lcd_segment_pin_select.sv
// Segment pin function select registers and charge pump pause control.
`timescale 1ns/1ps
`default_nettype none
`include "segpin_defs.svh"
// Operation
// - Enable bit set selects display, clear port.
// - Dedicated display pins stay segment outputs, except while srst holds.
// - 96-segment parts ignore lines 27 to 31.
// - Smaller parts ignore lines 35-47 or 43-47.
// - Third select register exists from 128 segments.
// - Fourth register, lines 48-50, only 192 segments.
// - Fourth register bits 15 to 3 read zero.
// - All enable bits read/write, reset to zero.
// - Pause bit 2 stops pump during conversions.
module lcd_segment_pin_select #(
   parameter int SEG_COUNT = `SEGPIN_SEG_COUNT,
   parameter int SMALL_TOP = 47
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire segpin_pkg::bus_req_s busReq,
   output logic [15:0] rdata,
   input wire segpin_pkg::line_vec_t dedicated,
   input wire segpin_pkg::line_vec_t segDrive,
   input wire segpin_pkg::line_vec_t portOut,
   input wire segpin_pkg::line_vec_t portOe,
   input wire logic display_master_on,
   input wire logic conversionBusy,
   input wire logic pumpEnable,
   output segpin_pkg::line_vec_t pinOut,
   output segpin_pkg::line_vec_t pinOe,
   output segpin_pkg::line_vec_t lcdSelected,
   output segpin_pkg::pump_stat_s pumpStat,
   output logic changedWhileOn
);
   import segpin_pkg::*;
   logic [15:0] sel0_q, sel1_q, sel2_q, sel3_q;
   logic [7:0] pump_pause_bits_q;
   logic convSync1_q, convSync2_q;
   line_vec_t implemented;
   line_vec_t segment_line_enable;
   line_vec_t useDisplay;
   logic hasSel2, hasSel3, selWr;

   assign hasSel2 = (SEG_COUNT >= 128);
   assign hasSel3 = (SEG_COUNT >= 192);

   // Lines beyond a variant's count are masked so stray writes cannot steer pins.
   genvar g;
   generate
      for (g = 0; g < 51; g++) begin : gImpl
         if (g >= 27 && g <= 31) begin : gMid
            assign implemented[g] = (SEG_COUNT > 96);
         end else if (g >= 32 && g <= 47) begin : gHi
            assign implemented[g] = hasSel2 && (g <= SMALL_TOP);
         end else if (g >= 48) begin : gTop
            assign implemented[g] = hasSel3;
         end else begin : gLow
            assign implemented[g] = 1'b1;
         end
      end
   endgenerate

   assign segment_line_enable = {sel3_q[2:0], sel2_q, sel1_q, sel0_q} & implemented;
   assign useDisplay = segment_line_enable | dedicated;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sel0_q <= `SEGPIN_RST_SEL;
         sel1_q <= `SEGPIN_RST_SEL;
         sel2_q <= `SEGPIN_RST_SEL;
         sel3_q <= `SEGPIN_RST_SEL;
      end else if (busReq.wr) begin
         unique case (busReq.addr)
            `SEGPIN_OFS_SEL0: sel0_q <= busReq.wdata;
            `SEGPIN_OFS_SEL1: sel1_q <= busReq.wdata;
            `SEGPIN_OFS_SEL2: if (hasSel2) sel2_q <= busReq.wdata;
            `SEGPIN_OFS_SEL3: if (hasSel3) sel3_q <= busReq.wdata & `SEGPIN_SEL3_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pump_pause_bits_q <= `SEGPIN_RST_PUMP;
      end else if (busReq.wr && busReq.addr == `SEGPIN_OFS_PUMP) begin
         pump_pause_bits_q <= busReq.wdata[7:0];
      end
   end

   // Read data stands one cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata <= 16'h0000;
      end else if (busReq.rd) begin
         unique case (busReq.addr)
            `SEGPIN_OFS_SEL0: rdata <= sel0_q;
            `SEGPIN_OFS_SEL1: rdata <= sel1_q;
            `SEGPIN_OFS_SEL2: rdata <= hasSel2 ? sel2_q : 16'h0000;
            `SEGPIN_OFS_SEL3: rdata <= hasSel3 ? (sel3_q & `SEGPIN_SEL3_MASK) : 16'h0000;
            `SEGPIN_OFS_PUMP: rdata <= {8'h00, pump_pause_bits_q};
            default: rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   assign selWr = busReq.wr && (busReq.addr == `SEGPIN_OFS_SEL0 || busReq.addr == `SEGPIN_OFS_SEL1
      || busReq.addr == `SEGPIN_OFS_SEL2 || busReq.addr == `SEGPIN_OFS_SEL3);

   // Flags a select write made while the display runs; glitches on the glass are likely then.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         changedWhileOn <= 1'b0;
      end else begin
         changedWhileOn <= selWr && display_master_on;
      end
   end

   // Conversion busy comes from another block's timing, so it is synchronised.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         convSync1_q <= 1'b0;
         convSync2_q <= 1'b0;
      end else begin
         convSync1_q <= conversionBusy;
         convSync2_q <= convSync1_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pumpStat <= '0;
      end else begin
         pumpStat.pumpPaused <= pump_pause_bits_q[`SEGPIN_PUMP_CONV_BIT] & convSync2_q;
         pumpStat.pumpRun <= pumpEnable &
            ~(pump_pause_bits_q[`SEGPIN_PUMP_CONV_BIT] & convSync2_q);
      end
   end

   seg_line_mux uMux (
      .ref_clk(ref_clk),
      .srst(srst),
      .lineEnable(segment_line_enable),
      .dedicated(dedicated),
      .segDrive(segDrive),
      .portOut(portOut),
      .portOe(portOe),
      .pinOut(pinOut),
      .pinOe(pinOe),
      .lcdSelected(lcdSelected)
   );

   property p_sel_reset;
      @(posedge ref_clk) srst |=> (sel0_q == 16'h0000 && sel1_q == 16'h0000 && sel3_q == 16'h0000);
   endproperty
   a_sel_reset: assert property (p_sel_reset) else $error("select not cleared by reset");

   property p_route;
      @(posedge ref_clk) disable iff (srst)
         1'b1 |=> lcdSelected == $past(segment_line_enable | dedicated);
   endproperty
   a_route: assert property (p_route) else $error("pin route wrong");

   property p_dedicated;
      @(posedge ref_clk) disable iff (srst)
         ($past(dedicated) == dedicated) |=> ((lcdSelected & $past(dedicated)) == $past(dedicated));
   endproperty
   a_dedicated: assert property (p_dedicated) else $error("dedicated pin left display");

   property p_sel3_zero;
      @(posedge ref_clk) disable iff (srst) sel3_q[15:3] == 13'h0;
   endproperty
   a_sel3_zero: assert property (p_sel3_zero) else $error("upper select bits set");

   property p_rd_sel3;
      @(posedge ref_clk) disable iff (srst)
         (busReq.rd && busReq.addr == `SEGPIN_OFS_SEL3) |=> rdata[15:3] == 13'h0;
   endproperty
   a_rd_sel3: assert property (p_rd_sel3) else $error("upper select bits read nonzero");

   property p_pump_rd;
      @(posedge ref_clk) disable iff (srst)
         (busReq.rd && busReq.addr == `SEGPIN_OFS_PUMP) |=> rdata == {8'h00, $past(pump_pause_bits_q)};
   endproperty
   a_pump_rd: assert property (p_pump_rd) else $error("pump readback wrong");

   property p_pause;
      @(posedge ref_clk) disable iff (srst)
         (conversionBusy && pump_pause_bits_q[2] && pumpEnable) [*4] |-> !pumpStat.pumpRun;
   endproperty
   a_pause: assert property (p_pause) else $error("pump kept running in conversion");

   property p_no_pause;
      @(posedge ref_clk) disable iff (srst)
         (!pump_pause_bits_q[2] && pumpEnable) [*2] |-> pumpStat.pumpRun;
   endproperty
   a_no_pause: assert property (p_no_pause) else $error("pump stopped without pause bit");

   property p_mid_masked;
      @(posedge ref_clk) disable iff (srst) (SEG_COUNT <= 96) |-> segment_line_enable[31:27] == 5'h0;
   endproperty
   a_mid_masked: assert property (p_mid_masked) else $error("reserved lines active");

   property p_hi_masked;
      @(posedge ref_clk) disable iff (srst) (!hasSel2) |-> segment_line_enable[50:32] == 19'h0;
   endproperty
   a_hi_masked: assert property (p_hi_masked) else $error("absent register active");

   property p_on_flag;
      @(posedge ref_clk) disable iff (srst) (selWr && display_master_on) |=> changedWhileOn;
   endproperty
   a_on_flag: assert property (p_on_flag) else $error("change while on not flagged");

   property p_rst_out;
      @(posedge ref_clk)
         srst |=> (rdata == 16'h0000 && sel2_q == `SEGPIN_RST_SEL && lcdSelected == '0
            && pinOe == '0 && pumpStat == '0 && !changedWhileOn);
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not reset");

   property p_wr_sel0;
      @(posedge ref_clk) disable iff (srst)
         (busReq.wr && busReq.addr == `SEGPIN_OFS_SEL0) |=> sel0_q == $past(busReq.wdata);
   endproperty
   a_wr_sel0: assert property (p_wr_sel0) else $error("select 0 write lost");

   property p_wr_sel1;
      @(posedge ref_clk) disable iff (srst)
         (busReq.wr && busReq.addr == `SEGPIN_OFS_SEL1) |=> sel1_q == $past(busReq.wdata);
   endproperty
   a_wr_sel1: assert property (p_wr_sel1) else $error("select 1 write lost");

   property p_wr_sel2;
      @(posedge ref_clk) disable iff (srst)
         (busReq.wr && busReq.addr == `SEGPIN_OFS_SEL2 && hasSel2)
            |=> sel2_q == $past(busReq.wdata);
   endproperty
   a_wr_sel2: assert property (p_wr_sel2) else $error("select 2 write lost");

   property p_wr_sel3;
      @(posedge ref_clk) disable iff (srst)
         (busReq.wr && busReq.addr == `SEGPIN_OFS_SEL3 && hasSel3)
            |=> sel3_q == ($past(busReq.wdata) & `SEGPIN_SEL3_MASK);
   endproperty
   a_wr_sel3: assert property (p_wr_sel3) else $error("sel3 write bad");

   property p_wr_pump;
      @(posedge ref_clk) disable iff (srst)
         (busReq.wr && busReq.addr == `SEGPIN_OFS_PUMP)
            |=> pump_pause_bits_q == $past(busReq.wdata[7:0]);
   endproperty
   a_wr_pump: assert property (p_wr_pump) else $error("pump write lost");

   property p_pump_hold;
      @(posedge ref_clk) disable iff (srst)
         !(busReq.wr && busReq.addr == `SEGPIN_OFS_PUMP) |=> $stable(pump_pause_bits_q);
   endproperty
   a_pump_hold: assert property (p_pump_hold) else $error("pump bits changed");

   property p_sel_hold;
      @(posedge ref_clk) disable iff (srst)
         !busReq.wr |=> $stable(sel0_q) && $stable(sel1_q) && $stable(sel2_q) && $stable(sel3_q);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select changed alone");

   property p_rd_sel0;
      @(posedge ref_clk) disable iff (srst)
         (busReq.rd && busReq.addr == `SEGPIN_OFS_SEL0) |=> rdata == $past(sel0_q);
   endproperty
   a_rd_sel0: assert property (p_rd_sel0) else $error("select 0 read wrong");

   property p_rd_sel2;
      @(posedge ref_clk) disable iff (srst)
         (busReq.rd && busReq.addr == `SEGPIN_OFS_SEL2)
            |=> rdata == (hasSel2 ? $past(sel2_q) : 16'h0000);
   endproperty
   a_rd_sel2: assert property (p_rd_sel2) else $error("select 2 read wrong");

   property p_rd_idle;
      @(posedge ref_clk) disable iff (srst)
         !busReq.rd |=> rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");

   property p_rd_unmap;
      @(posedge ref_clk) disable iff (srst)
         (busReq.rd && (busReq.addr[0] || busReq.addr > `SEGPIN_OFS_PUMP)) |=> rdata == 16'h0000;
   endproperty
   a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read nonzero");

   property p_pin_val;
      @(posedge ref_clk) disable iff (srst)
         1'b1 |=> pinOut == (($past(useDisplay) & $past(segDrive))
            | (~$past(useDisplay) & $past(portOut)));
   endproperty
   a_pin_val: assert property (p_pin_val) else $error("pin value wrong");

   property p_pin_oe;
      @(posedge ref_clk) disable iff (srst)
         1'b1 |=> pinOe == ($past(useDisplay) | $past(portOe));
   endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");

   property p_pump_off;
      @(posedge ref_clk) disable iff (srst)
         !pumpEnable |=> !pumpStat.pumpRun;
   endproperty
   a_pump_off: assert property (p_pump_off) else $error("pump ran while off");

   property p_pause_bit;
      @(posedge ref_clk) disable iff (srst)
         !pump_pause_bits_q[`SEGPIN_PUMP_CONV_BIT] |=> !pumpStat.pumpPaused;
   endproperty
   a_pause_bit: assert property (p_pause_bit) else $error("paused without bit");

   property p_pause_excl;
      @(posedge ref_clk) disable iff (srst)
         1'b1 |-> !(pumpStat.pumpRun && pumpStat.pumpPaused);
   endproperty
   a_pause_excl: assert property (p_pause_excl) else $error("run and pause both");

   property p_flag_off;
      @(posedge ref_clk) disable iff (srst)
         !display_master_on |=> !changedWhileOn;
   endproperty
   a_flag_off: assert property (p_flag_off) else $error("flag while display off");

   property p_low_lines;
      @(posedge ref_clk) disable iff (srst)
         1'b1 |-> segment_line_enable[26:0] == {sel1_q[10:0], sel0_q};
   endproperty
   a_low_lines: assert property (p_low_lines) else $error("low line enable wrong");

   property p_mid_lines;
      @(posedge ref_clk) disable iff (srst)
         (SEG_COUNT > 96) |-> segment_line_enable[31:27] == sel1_q[15:11];
   endproperty
   a_mid_lines: assert property (p_mid_lines) else $error("mid line enable wrong");

   property p_hi_lines;
      @(posedge ref_clk) disable iff (srst)
         (hasSel2 && SMALL_TOP >= 47) |-> segment_line_enable[47:32] == sel2_q;
   endproperty
   a_hi_lines: assert property (p_hi_lines) else $error("hi lines wrong");

   property p_top_lines;
      @(posedge ref_clk) disable iff (srst)
         hasSel3 |-> segment_line_enable[50:48] == sel3_q[2:0];
   endproperty
   a_top_lines: assert property (p_top_lines) else $error("top line enable wrong");

   c_seg_write: cover property (@(posedge ref_clk) busReq.wr && busReq.addr == `SEGPIN_OFS_SEL0);
   c_lcd_pin: cover property (@(posedge ref_clk) lcdSelected[5]);
   c_paused: cover property (@(posedge ref_clk) pumpStat.pumpPaused);
   c_sel3_rd: cover property (@(posedge ref_clk) busReq.rd && busReq.addr == `SEGPIN_OFS_SEL3);
   c_on_write: cover property (@(posedge ref_clk) changedWhileOn);
endmodule
`default_nettype wire

//--- segpin_defs.svh
// Register offsets, reset values and variant constants for the segment pin select block.
`ifndef SEGPIN_DEFS_SVH
`define SEGPIN_DEFS_SVH
`define SEGPIN_OFS_SEL0 4'h0
`define SEGPIN_OFS_SEL1 4'h2
`define SEGPIN_OFS_SEL2 4'h4
`define SEGPIN_OFS_SEL3 4'h6
`define SEGPIN_OFS_PUMP 4'h8
`define SEGPIN_RST_SEL 16'h0000
`define SEGPIN_RST_PUMP 8'h00
`define SEGPIN_SEL3_MASK 16'h0007
`define SEGPIN_PUMP_MASK 16'h00ff
`define SEGPIN_PUMP_CONV_BIT 2
`define SEGPIN_LINES 51
`define SEGPIN_SEG_COUNT 192
`endif

//--- segpin_pkg.sv
// Types shared by the segment pin select block.
package segpin_pkg;
   typedef logic [50:0] line_vec_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;
   typedef struct packed {
      logic pumpRun;
      logic pumpPaused;
   } pump_stat_s;
endpackage

//--- seg_line_mux.sv
// Per-line steering between display driver and port logic.
`timescale 1ns/1ps
`default_nettype none
module seg_line_mux (
   input wire logic ref_clk,
   input wire logic srst,
   input wire segpin_pkg::line_vec_t lineEnable,
   input wire segpin_pkg::line_vec_t dedicated,
   input wire segpin_pkg::line_vec_t segDrive,
   input wire segpin_pkg::line_vec_t portOut,
   input wire segpin_pkg::line_vec_t portOe,
   output segpin_pkg::line_vec_t pinOut,
   output segpin_pkg::line_vec_t pinOe,
   output segpin_pkg::line_vec_t lcdSelected
);
   import segpin_pkg::*;
   genvar g;
   generate
      for (g = 0; g < 51; g++) begin : gLine
         logic useLcd;
         assign useLcd = dedicated[g] | lineEnable[g];
         always_ff @(posedge ref_clk) begin
            if (srst) begin
               pinOut[g] <= 1'b0;
               pinOe[g] <= 1'b0;
               lcdSelected[g] <= 1'b0;
            end else begin
               pinOut[g] <= useLcd ? segDrive[g] : portOut[g];
               pinOe[g] <= useLcd ? 1'b1 : portOe[g];
               lcdSelected[g] <= useLcd;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

//--- seg_far_side.sv
// Far-side model: display glass drive levels, port logic values and a converter busy line.
`timescale 1ns/1ps
`default_nettype none
module seg_far_side (
   input wire logic ref_clk,
   input wire logic shuffle,
   input wire logic convReq,
   output segpin_pkg::line_vec_t segDrive,
   output segpin_pkg::line_vec_t portOut,
   output segpin_pkg::line_vec_t portOe,
   output logic conversionBusy
);
   import segpin_pkg::*;
   int farSeed = 32'h13572468;
   initial begin
      segDrive = '0;
      portOut = '0;
      portOe = '0;
      conversionBusy = 1'b0;
   end
   // New levels arrive only on request, so the bench can check a settled mux.
   always @(posedge ref_clk) begin
      if (shuffle) begin
         segDrive <= line_vec_t'({$random(farSeed), $random(farSeed)});
         portOut <= line_vec_t'({$random(farSeed), $random(farSeed)});
         portOe <= line_vec_t'({$random(farSeed), $random(farSeed)});
      end
   end
   // Busy follows the request 7 ns later, so it moves off the bus clock edges.
   always @(convReq) conversionBusy <= #7 convReq;
endmodule
`default_nettype wire

//--- lcd_segment_pin_select_tb.sv
// Self-checking bench for the segment pin select block.
`timescale 1ns/1ps
`default_nettype none
`include "segpin_defs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
   $display("unexpected at %0t: got %h want %h", $time, (got), (exp)); end end
module lcd_segment_pin_select_tb;
   import segpin_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   bus_req_s busReq = '0;
   logic [15:0] rdata;
   line_vec_t dedicated = '0;
   line_vec_t segDrive, portOut, portOe, pinOut, pinOe, lcdSelected;
   logic displayOn = 1'b0;
   logic convReq = 1'b0;
   logic pumpEnable = 1'b0;
   logic shuffle = 1'b0;
   logic changedWhileOn;
   logic convBusy;
   pump_stat_s pumpStat;
   int n_fail = 0;
   int checks_done = 0;
   int seed = 32'h59dbb03f;
   int seen;
   logic [15:0] expQ[$];
   logic [15:0] expNow;
   logic rdSeen = 1'b0;
   logic [15:0] shadow[5];
   always #12.5 ref_clk = ~ref_clk;
   lcd_segment_pin_select u_lcd_segment_pin_select (.ref_clk(ref_clk), .srst(srst),
      .busReq(busReq), .rdata(rdata), .dedicated(dedicated), .segDrive(segDrive),
      .portOut(portOut), .portOe(portOe), .display_master_on(displayOn),
      .conversionBusy(convBusy), .pumpEnable(pumpEnable),
      .pinOut(pinOut), .pinOe(pinOe), .lcdSelected(lcdSelected), .pumpStat(pumpStat),
      .changedWhileOn(changedWhileOn));
   seg_far_side u_seg_far_side (.ref_clk(ref_clk), .shuffle(shuffle), .convReq(convReq),
      .segDrive(segDrive), .portOut(portOut), .portOe(portOe), .conversionBusy(convBusy));
   // Reads leave their expected word in the queue; read data stand one cycle later.
   always @(posedge ref_clk) begin
      rdSeen <= busReq.rd;
      if (rdSeen) begin
         expNow = expQ.pop_front();
         `CHK(rdata, expNow)
      end
   end
   task automatic op(input logic isWr, input logic [3:0] a, input logic [15:0] d);
      busReq <= '{addr: a, wdata: d, wr: isWr, rd: !isWr};
      if (!isWr) expQ.push_back(d);
      @(posedge ref_clk);
   endtask
   task automatic idle(input int n);
      busReq <= '0;
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic check_pins(input line_vec_t sel);
      line_vec_t e;
      shuffle <= 1'b1;
      dedicated <= line_vec_t'({$random(seed), $random(seed)});
      idle(1);
      shuffle <= 1'b0;
      idle(4);
      e = sel | dedicated;
      `CHK(lcdSelected, e)
      `CHK(pinOut, (e & segDrive) | (~e & portOut))
      `CHK(pinOe, e | portOe)
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i <= 10; i += 2) op(1'b0, 4'(i), 16'h0000);
      idle(2);
      $display("test reset values done");
      for (int i = 0; i < 5; i++) shadow[i] = 16'($random(seed));
      for (int i = 0; i < 5; i++) op(1'b1, 4'(2 * i), shadow[i]);
      op(1'b1, 4'ha, 16'hffff);
      for (int i = 0; i < 4; i++) op(1'b0, 4'(2 * i), i == 3 ? shadow[3] & 16'h0007 : shadow[i]);
      op(1'b0, `SEGPIN_OFS_PUMP, shadow[4] & 16'h00ff);
      op(1'b0, 4'ha, 16'h0000);
      idle(2);
      $display("test register access done");
      check_pins({shadow[3][2:0], shadow[2], shadow[1], shadow[0]});
      for (int i = 0; i < 4; i++) op(1'b1, 4'(2 * i), 16'h0000);
      check_pins('0);
      $display("test pin steering done");
      pumpEnable <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         op(1'b1, `SEGPIN_OFS_PUMP, k == 0 ? 16'h0004 : 16'h00fb);
         idle(4);
         `CHK(pumpStat, pump_stat_s'(2'b10))
         convReq <= 1'b1;
         idle(6);
         `CHK(pumpStat, k == 0 ? pump_stat_s'(2'b01) : pump_stat_s'(2'b10))
         convReq <= 1'b0;
         idle(6);
         `CHK(pumpStat, pump_stat_s'(2'b10))
      end
      $display("test pump pause done");
      // Selects written while the display runs still land, but are flagged once.
      displayOn <= 1'b1;
      op(1'b1, `SEGPIN_OFS_SEL0, 16'h00a5);
      idle(1);
      seen = 0;
      repeat (4) begin
         seen += (changedWhileOn === 1'b1);
         @(posedge ref_clk);
      end
      `CHK(seen, 1)
      op(1'b0, `SEGPIN_OFS_SEL0, 16'h00a5);
      displayOn <= 1'b0;
      idle(3);
      $display("test write while on done");
      // A reset in mid-run must hand every shared pin back to port function.
      srst <= 1'b1;
      idle(2);
      srst <= 1'b0;
      idle(1);
      op(1'b0, `SEGPIN_OFS_SEL0, `SEGPIN_RST_SEL);
      op(1'b0, `SEGPIN_OFS_PUMP, 16'h0000);
      idle(3);
      `CHK(lcdSelected, dedicated)
      $display("test mid-run reset done");
      tally_and_finish();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_fail++;
      $display("unexpected at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire
